// ===== src/pcpd_pkg.sv
/*
  pcpd_pkg: constants and carrier types for the pin-controlled power-down
  block. Assumes a single 40 MHz clock domain.
*/
package pcpd_pkg;
  localparam int unsigned NUM_PINS      = 8;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned RECOVER_US    = 1;
  // longest time: round down, at least one cycle
  localparam int unsigned RECOVER_CYC_RAW =
    (RECOVER_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYC =
    (RECOVER_CYC_RAW < 1) ? 1 : RECOVER_CYC_RAW;
  localparam int unsigned RCNT_W = 6;
  localparam logic [RCNT_W-1:0] RCNT_RST  = 6'h00;
  // cycles spent outside the countdown: two synchroniser stages, the
  // state register, the hold latch and half a cycle of pin skew
  localparam int unsigned WAKE_LAT_CYC = 5;
  localparam logic [RCNT_W-1:0] RCNT_LOAD =
    RCNT_W'(RECOVER_CYC - 1 - WAKE_LAT_CYC);
  localparam logic [NUM_PINS-1:0] PINS_RST = 8'h00;

  typedef enum logic [1:0] {PCPD_RUN, PCPD_SLEEP, PCPD_WAKE} pcpd_state_type;

  // one group of pin signals
  typedef struct packed {
    logic [NUM_PINS-1:0] val;
    logic [NUM_PINS-1:0] oe;
  } pcpd_pins_type;
endpackage

// ===== src/pcpd_sync.sv
/*
  pcpd_sync: two flip-flop synchroniser for a vector of pin levels.
  Assumes the inputs are asynchronous to clk.
*/
module pcpd_sync
  import pcpd_pkg::*;
#(parameter int unsigned W = 1)
(
  input  wire logic         clk,    // system clock
  input  wire logic         arst_n, // async reset, active low
  input  wire logic [W-1:0] d,      // asynchronous level
  output logic      [W-1:0] q       // synchronised level
);
  logic [W-1:0] meta_reg;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ===== src/pcpd_top.sv
/*
  pcpd_top: power-down gating between device pins and its core logic.
  Assumes the core logic runs on clk and honours core_hold_o by freezing.
  Pin inputs are asynchronous and synchronised here.
*/
// Summary of operation
// R1: with option enabled, the sleep pin acts as power-down control.
// R2: sleep pin high enters power-down; far side holds it high.
// R3: outputs and internal state latch and hold during power-down.
// R4: outputs tristated at entry remain tristated throughout power-down.
// R5: all inputs except the sleep pin are blocked while asleep.
// R6: pin hold latches stay active, keeping last pin levels.
// R7: option is static; disabled, the pin is an ordinary input.
// R8: enabled, the sleep pin never feeds the logic array as data.
// R9: after sleep pin low, full operation resumes within 1 us.
// R10: leaving power-down resumes from held state, no reset.
module pcpd_top
  import pcpd_pkg::*;
#(parameter bit PD_ENABLE = 1'b1)
(
  input  wire logic                clk,               // system clock
  input  wire logic                arst_n,            // async reset
  input  wire logic                sleep_request_pin, // sleep pin level
  input  wire logic [NUM_PINS-1:0] pin_in,            // pin input levels
  input  pcpd_pins_type            core_out,          // core outputs+oe
  output pcpd_pins_type            pin_out,           // pin drive + oe
  output logic      [NUM_PINS-1:0] core_in,           // inputs to core
  output logic                     sleep_as_data,     // pin as data input
  output logic                     core_hold_o,       // freeze core state
  output logic                     keeper_en,         // hold latches on
  output logic                     asleep             // in power-down
);
  logic                sleep_s;      // synced sleep pin level
  logic [NUM_PINS-1:0] pin_s;        // synced pin levels
  pcpd_state_type      state_reg;    // run, sleep or wake
  pcpd_state_type      state_next;   // next state
  logic [RCNT_W-1:0]   rcnt_reg;     // recovery countdown
  logic                sleep_req;    // qualified power-down request
  logic                capture;      // hold latches follow their source
  logic [RCNT_W-1:0]   wake_age_reg; // cycles since the request dropped
  logic                wake_age_run; // age counter is counting

  pcpd_sync #(.W(NUM_PINS + 1)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({sleep_request_pin, pin_in}),
    .q      ({sleep_s, pin_s})
  );

  // the option is a static strap, so a plain parameter gates it; with
  // the option off the request never reaches the sequencer
  assign sleep_req = PD_ENABLE && sleep_s; // see R1 see R7

  // run / sleep / wake sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PCPD_RUN: begin
        if (sleep_req) begin
          state_next = PCPD_SLEEP; // see R2
        end
      end
      PCPD_SLEEP: begin
        // stay asleep for as long as the far side holds the pin high
        if (!sleep_req) begin
          state_next = PCPD_WAKE;
        end
      end
      PCPD_WAKE: begin
        // a new request during recovery goes straight back to sleep
        if (sleep_req) begin
          state_next = PCPD_SLEEP;
        end else if (rcnt_reg == RCNT_RST) begin
          state_next = PCPD_RUN; // see R9
        end
      end
      default: begin
        state_next = PCPD_RUN;
      end
    endcase
  end

  // state register; only arst_n resets it, waking never does
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= PCPD_RUN;
    end else begin
      state_reg <= state_next; // see R10
    end
  end

  // recovery countdown, reloaded while asleep; the load value leaves
  // room for the synchroniser and the hold latch inside 1 us
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rcnt_reg <= RCNT_RST;
    end else if (state_reg == PCPD_SLEEP) begin
      rcnt_reg <= RCNT_LOAD; // see R9
    end else if (rcnt_reg != RCNT_RST) begin
      rcnt_reg <= rcnt_reg - 6'h01;
    end
  end

  // latches follow their sources only when the next state is run, so
  // the last pre-sleep values stay frozen through sleep and recovery
  assign capture = (state_next == PCPD_RUN); // see R3 see R5

  // per-pin hold latches; value and enable are held together, so a pin
  // that was tristate at entry cannot start driving while asleep
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    logic in_bit_reg;  // level handed to the core
    logic val_bit_reg; // level driven on the pin
    logic oe_bit_reg;  // pin drive enable

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        in_bit_reg  <= PINS_RST[i];
        val_bit_reg <= PINS_RST[i];
        oe_bit_reg  <= PINS_RST[i];
      end else if (capture) begin
        in_bit_reg  <= pin_s[i];        // see R5 see R6
        val_bit_reg <= core_out.val[i]; // see R3
        oe_bit_reg  <= core_out.oe[i];  // see R4
      end
    end

    assign core_in[i]     = in_bit_reg;
    assign pin_out.val[i] = val_bit_reg;
    assign pin_out.oe[i]  = oe_bit_reg;

    chk_tri_kept: assert property (@(posedge clk) disable iff (!arst_n)
      core_hold_o && $past(core_hold_o) && !$past(pin_out.oe[i])
      |-> !pin_out.oe[i]) // see R4
      else $error("tristate pin started driving while held");
  end

  // age of the current recovery, only for checking the wake bound
  assign wake_age_run = core_hold_o && !sleep_req;

  // saturates so that a stuck hold cannot wrap back into range
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_age_reg <= RCNT_RST;
    end else if (!wake_age_run) begin
      wake_age_reg <= RCNT_RST;
    end else if (wake_age_reg != 6'h3F) begin
      wake_age_reg <= wake_age_reg + 6'h01;
    end
  end

  // core is frozen, never reset, so it resumes where it stopped
  assign core_hold_o = (state_reg != PCPD_RUN); // see R3 see R10
  assign asleep      = (state_reg == PCPD_SLEEP);
  assign keeper_en   = (state_reg != PCPD_RUN); // see R6
  // enabled: pin carries no data into the array
  assign sleep_as_data = PD_ENABLE ? 1'b0 : sleep_s; // see R8 see R7

  // request steps: rise, drop, then release of the core
  sequence seq_req_rise;
    $rose(sleep_req);
  endsequence
  sequence seq_req_drop;
    $fell(sleep_req);
  endsequence
  sequence seq_core_free;
    ##[1:40] (!core_hold_o || sleep_req);
  endsequence

  chk_sleep_entry: assert property (@(posedge clk) disable iff (!arst_n)
    seq_req_rise |=> asleep) // see R2
    else $error("sleep not entered");
  chk_out_frozen: assert property (@(posedge clk) disable iff (!arst_n)
    asleep && $past(asleep) |-> $stable(pin_out)) // see R3
    else $error("outputs moved while asleep");
  chk_oe_frozen: assert property (@(posedge clk) disable iff (!arst_n)
    asleep && $past(asleep) |-> $stable(pin_out.oe)) // see R4
    else $error("enable moved while asleep");
  chk_in_blocked: assert property (@(posedge clk) disable iff (!arst_n)
    core_hold_o && $past(core_hold_o) |-> $stable(core_in)) // see R5
    else $error("input reached core while asleep");
  chk_keeper_on: assert property (@(posedge clk) disable iff (!arst_n)
    asleep |-> keeper_en && core_hold_o) // see R6
    else $error("keeper off while asleep");
  chk_no_data_use: assert property (@(posedge clk) disable iff (!arst_n)
    PD_ENABLE |-> !sleep_as_data) // see R8
    else $error("sleep pin used as data");
  chk_disabled: assert property (@(posedge clk) disable iff (!arst_n)
    !PD_ENABLE |-> !core_hold_o) // see R7
    else $error("power-down while option disabled");
  chk_wake_time: assert property (@(posedge clk) disable iff (!arst_n)
    seq_req_drop |-> seq_core_free) // see R9
    else $error("recovery too slow");
  chk_enable_use: assert property (@(posedge clk) disable iff (!arst_n)
    PD_ENABLE && sleep_req && !core_hold_o |=> core_hold_o) // see R1
    else $error("pin not used as control");
  chk_wake_hold: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(asleep) |-> core_hold_o) // see R10
    else $error("core released without recovery");
  chk_keeper_match: assert property (@(posedge clk) disable iff (!arst_n)
    keeper_en == core_hold_o) // see R6
    else $error("keeper and hold disagree");
  chk_wake_age: assert property (@(posedge clk) disable iff (!arst_n)
    wake_age_reg <= RCNT_W'(RECOVER_CYC)) // see R9
    else $error("core held past recovery bound");
  chk_run_follow: assert property (@(posedge clk) disable iff (!arst_n)
    !core_hold_o && !sleep_req |=> core_in == $past(pin_s)) // see R3
    else $error("inputs not followed while running");
endmodule

// ===== tb/pcpd_sleep_drv.sv
/*
  pcpd_sleep_drv: model of the system logic that drives the sleep pin.
  Assumes clk is the device clock and the bench calls its tasks.
*/
module pcpd_sleep_drv (
  input  wire logic clk,               // system clock
  output logic      sleep_request_pin  // level to the device
);
  timeunit 1ns;
  timeprecision 100ps;
  initial sleep_request_pin = 1'b0;
  // level changes only at a falling edge, then holds until told otherwise
  task automatic set_level(input logic lvl);
    @(negedge clk);
    sleep_request_pin = lvl;
  endtask
  // the caller gets control back only after wait_cyc more falling edges have passed
  task automatic release_pin(input int unsigned wait_cyc);
    set_level(1'b0);
    repeat (wait_cyc) @(negedge clk);
  endtask
endmodule

// ===== tb/pcpd_top_test.sv
/*
  pcpd_top_test: self-checking bench for the power-down gating block.
  Assumes pcpd_pkg and pcpd_top are compiled first; one 40 MHz clock.
*/
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  failures++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module pcpd_top_test;
  import pcpd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, sleep_request_pin, sad_off, asl_off;
  logic [NUM_PINS-1:0] pin_in, core_in;
  logic sleep_as_data, core_hold_o, keeper_en, asleep;
  pcpd_pins_type core_out, pin_out;
  int failures = 0;
  int tests_run = 0;
  pcpd_sleep_drv far_u (.clk(clk), .sleep_request_pin(sleep_request_pin));
  pcpd_top dut_u (.clk(clk), .arst_n(arst_n), .sleep_request_pin,
    .pin_in, .core_out, .pin_out, .core_in, .sleep_as_data,
    .core_hold_o, .keeper_en, .asleep);
  // option off: the same pin must act as plain data
  pcpd_top #(.PD_ENABLE(1'b0)) dut_off (.clk(clk), .arst_n(arst_n),
    .sleep_request_pin, .pin_in, .core_out, .pin_out(), .core_in(),
    .sleep_as_data(sad_off), .core_hold_o(), .keeper_en(),
    .asleep(asl_off));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic final_report;
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // plain running: inputs pass through, core outputs reach the pins
  task automatic run_pass;
    pin_in = 8'hA5;
    core_out = '{val: 8'h3C, oe: 8'hF0};
    cyc(4);
    `CHK("core_in", 8'hA5, core_in)
    `CHK("pin_out", 16'h3CF0, pin_out)
  endtask
  // sleep with inputs moving, then wake and resume from held state
  task automatic sleep_wake;
    far_u.set_level(1'b1);
    cyc(4);
    `CHK("asleep", 1'b1, asleep)
    `CHK("keeper", 1'b1, keeper_en)
    `CHK("sad", 1'b0, sleep_as_data)
    `CHK("sad_off", 1'b1, sad_off)
    `CHK("asl_off", 1'b0, asl_off)
    pin_in = 8'h5A;
    core_out = '{val: 8'hC3, oe: 8'h0F};
    cyc(10);
    `CHK("core_in held", 8'hA5, core_in)
    `CHK("pin_out held", 16'h3CF0, pin_out)
    far_u.release_pin(30);
    `CHK("still held", 1'b1, core_hold_o)
    `CHK("kept", 8'hA5, core_in)
    `CHK("pin_out kept", 16'h3CF0, pin_out)
    cyc(10);
    `CHK("hold off", 1'b0, core_hold_o)
    `CHK("asleep off", 1'b0, asleep)
    `CHK("keeper off", 1'b0, keeper_en)
    `CHK("core_in new", 8'h5A, core_in)
    `CHK("pin_out new", 16'hC30F, pin_out)
  endtask
  initial begin
    arst_n = 1'b0;
    pin_in = 8'h00;
    core_out = '0;
    cyc(20);
    `CHK("rst", 1'b0, core_hold_o)
    arst_n = 1'b1;
    run_pass();
    sleep_wake();
    final_report();
  end
  // tests take about 80 cycles; a hang is cut off well past that
  initial begin
    #(2000 * 25);
    failures++;
    final_report();
  end
endmodule
